// [src/tcg_defines.vh]
// tcg_defines.vh: register offsets, field positions, reset values and mode codes
// for the timer configuration block. assumes byte addressing on a 32-bit AXI4-Lite bus.
`ifndef TCG_DEFINES_VH
`define TCG_DEFINES_VH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define TCG_OFF_CTL0 4'h0
`define TCG_OFF_CTL1 4'h4
`define TCG_OFF_IOC0 4'h8
`define TCG_OFF_CNT 4'hc

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define TCG_CTL0_CE 7
`define TCG_CTL0_CKS_LO 0
`define TCG_CTL0_CKS_HI 2
`define TCG_CTL1_EST 6
`define TCG_CTL1_EEE 5
`define TCG_CTL1_MD_LO 0
`define TCG_CTL1_MD_HI 2
`define TCG_IOC0_OE0 0
`define TCG_IOC0_OL0 1
`define TCG_IOC0_OE1 2
`define TCG_IOC0_OL1 3

// ----------------------------------------------------------------
// reset values and mode codes
// ----------------------------------------------------------------
`define TCG_RST_CTL0 8'h00
`define TCG_RST_CTL1 8'h00
`define TCG_RST_IOC0 4'h0
`define TCG_MD_EXT_EVENT 3'h1
`define TCG_MD_EXT_TRIG 3'h2
`define TCG_MD_ONE_SHOT 3'h3

// ----------------------------------------------------------------
// bus responses
// ----------------------------------------------------------------
`define TCG_RESP_OKAY 2'h0
`define TCG_RESP_SLVERR 2'h2

`endif

// [src/tcg_prescaler.v]
// tcg_prescaler.v: count clock select, turns the core clock into a one-cycle tick.
// assumes an asynchronous active-low reset copy, released synchronously by the top module.
`timescale 1ns/10ps
module tcg_prescaler #(
    parameter DIV_W = 8
) (
    // clock and reset
    input wire core_clk_i,
    input wire rst_n_i,
    // control
    input wire run_i,
    input wire [2:0] sel_i,
    // tick out
    output reg tick_o
);

    reg [DIV_W-1:0] div; // free divider, cleared while stopped
    // low select bits of the divider; all ones marks the end of a period
    wire [DIV_W-1:0] low_mask = ~({DIV_W{1'b1}} << sel_i);

    // ----------------------------------------------------------------
    // divider: select n gives a tick every 2^n core cycles
    // ----------------------------------------------------------------
    always @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            div <= {DIV_W{1'b0}};
            tick_o <= 1'b0;
        end else if (!run_i) begin
            // stopped: restart phase so the first period is full
            div <= {DIV_W{1'b0}};
            tick_o <= 1'b0;
        end else begin
            div <= div + {{(DIV_W-1){1'b0}}, 1'b1};
            // select 0 gives an empty mask, so every cycle ticks
            tick_o <= ((div & low_mask) == low_mask);
        end
    end

endmodule // tcg_prescaler

// [src/tcg_timer_cfg.v]
// tcg_timer_cfg.v: control and output configuration of a 16-bit timer channel,
// with an AXI4-Lite register slave. assumes a single core clock at 25 MHz.
//
// Overview of operation
// - software trigger works only in trigger modes
// - other modes ignore software trigger writes
// - event count mode always counts external input
// - output pin follows level bit always
// - mode code 001 is external event count
// - codes 010 trigger, 011 one-shot pulse
`timescale 1ns/10ps
`include "tcg_defines.vh"
module tcg_timer_cfg #(
    parameter CNT_W = 16,
    parameter DIV_W = 8
) (
    // clock and reset
    input wire core_clk_i,
    input wire resetn_i,
    // axi4-lite write address
    input wire [3:0] s_axi_awaddr_i,
    input wire s_axi_awvalid_i,
    output reg s_axi_awready_o,
    // axi4-lite write data
    input wire [31:0] s_axi_wdata_i,
    input wire [3:0] s_axi_wstrb_i,
    input wire s_axi_wvalid_i,
    output reg s_axi_wready_o,
    // axi4-lite write response
    output reg [1:0] s_axi_bresp_o,
    output reg s_axi_bvalid_o,
    input wire s_axi_bready_i,
    // axi4-lite read address
    input wire [3:0] s_axi_araddr_i,
    input wire s_axi_arvalid_i,
    output reg s_axi_arready_o,
    // axi4-lite read data
    output reg [31:0] s_axi_rdata_o,
    output reg [1:0] s_axi_rresp_o,
    output reg s_axi_rvalid_o,
    input wire s_axi_rready_i,
    // timer pins
    input wire ext_event_i,
    output reg [1:0] timer_output_pin_o,
    output reg trigger_pulse_o
);

    // ----------------------------------------------------------------
    // reset release
    // ----------------------------------------------------------------
    reg rst_meta; // first release stage
    reg rst_n; // released reset used by the design

    // reset is asserted at once and released two edges later
    always @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            rst_meta <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n <= rst_meta;
        end
    end

    // ----------------------------------------------------------------
    // registers and state
    // ----------------------------------------------------------------
    reg [7:0] timer_control_first; // count enable and clock select
    reg [7:0] timer_control_second; // mode, event enable
    reg [3:0] timer_output_control; // level and enable per output
    reg [CNT_W-1:0] count; // the 16-bit counter
    reg ev_d; // previous external event level
    reg [3:0] aw_addr; // captured write address
    reg aw_held; // write address taken
    reg [31:0] w_data; // captured write data
    reg [3:0] w_strb; // captured byte enables
    reg w_held; // write data taken
    wire count_enable = timer_control_first[`TCG_CTL0_CE];
    wire [2:0] mode = timer_control_second[`TCG_CTL1_MD_HI:`TCG_CTL1_MD_LO];
    wire eee = timer_control_second[`TCG_CTL1_EEE];
    wire tick; // prescaled count clock tick
    wire ev_edge = ext_event_i & ~ev_d; // rising edge of the event input

    // true when the mode honours the software trigger
    function trig_mode;
        input [2:0] m;
        begin
            trig_mode = (m == `TCG_MD_EXT_TRIG) || (m == `TCG_MD_ONE_SHOT);
        end
    endfunction

    // ----------------------------------------------------------------
    // count clock prescaler
    // ----------------------------------------------------------------
    tcg_prescaler #(
        .DIV_W(DIV_W)
    ) u_presc (
        .core_clk_i(core_clk_i),
        .rst_n_i(rst_n),
        .run_i(count_enable),
        .sel_i(timer_control_first[`TCG_CTL0_CKS_HI:`TCG_CTL0_CKS_LO]),
        .tick_o(tick)
    );

    // ----------------------------------------------------------------
    // write channel: address and data taken in either order
    // ----------------------------------------------------------------
    wire do_write = aw_held && w_held && !s_axi_bvalid_o;
    wire sw_trig_wr = do_write && (aw_addr == `TCG_OFF_CTL1) && w_strb[0] &&
                      w_data[`TCG_CTL1_EST];

    // slave register writes; settings writes are stored as given, software keeps
    // them stable while counting, so no hardware lockout is spent on it
    always @(posedge core_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            s_axi_awready_o <= 1'b1;
            s_axi_wready_o <= 1'b1;
            s_axi_bvalid_o <= 1'b0;
            s_axi_bresp_o <= `TCG_RESP_OKAY;
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= 4'h0;
            w_data <= 32'h0;
            w_strb <= 4'h0;
            timer_control_first <= `TCG_RST_CTL0;
            timer_control_second <= `TCG_RST_CTL1;
            timer_output_control <= `TCG_RST_IOC0;
        end else begin
            // accept address
            if (s_axi_awvalid_i && s_axi_awready_o) begin
                aw_addr <= s_axi_awaddr_i;
                aw_held <= 1'b1;
                s_axi_awready_o <= 1'b0;
            end
            // accept data
            if (s_axi_wvalid_i && s_axi_wready_o) begin
                w_data <= s_axi_wdata_i;
                w_strb <= s_axi_wstrb_i;
                w_held <= 1'b1;
                s_axi_wready_o <= 1'b0;
            end
            // both halves present: update and answer
            if (do_write) begin
                s_axi_bvalid_o <= 1'b1;
                s_axi_bresp_o <= `TCG_RESP_OKAY;
                case (aw_addr)
                    `TCG_OFF_CTL0: begin
                        // clock select may ride with the enable write
                        // bits 3-6 reserved, kept zero
                        if (w_strb[0]) begin
                            timer_control_first <= w_data[7:0] & 8'h87;
                        end
                    end
                    `TCG_OFF_CTL1: begin
                        // trigger bit is self-clearing, never stored
                        // bits 3-4 reserved, kept zero
                        // mode and event enable stored; recovery is stop then rewrite
                        if (w_strb[0]) begin
                            timer_control_second <= w_data[7:0] & 8'h27;
                        end
                    end
                    `TCG_OFF_IOC0: begin
                        // levels and enables stored at once
                        if (w_strb[0]) begin
                            timer_output_control <= w_data[3:0];
                        end
                    end
                    `TCG_OFF_CNT: begin
                        // counter is read only
                        s_axi_bresp_o <= `TCG_RESP_SLVERR;
                    end
                    default: begin
                        s_axi_bresp_o <= `TCG_RESP_SLVERR;
                    end
                endcase
            end
            // response taken: reopen both channels
            if (s_axi_bvalid_o && s_axi_bready_i) begin
                s_axi_bvalid_o <= 1'b0;
                aw_held <= 1'b0;
                w_held <= 1'b0;
                s_axi_awready_o <= 1'b1;
                s_axi_wready_o <= 1'b1;
            end
        end
    end

    // ----------------------------------------------------------------
    // read channel
    // ----------------------------------------------------------------
    always @(posedge core_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            s_axi_arready_o <= 1'b1;
            s_axi_rvalid_o <= 1'b0;
            s_axi_rdata_o <= 32'h0;
            s_axi_rresp_o <= `TCG_RESP_OKAY;
        end else begin
            if (s_axi_arvalid_i && s_axi_arready_o) begin
                s_axi_arready_o <= 1'b0;
                s_axi_rvalid_o <= 1'b1;
                s_axi_rresp_o <= `TCG_RESP_OKAY;
                case (s_axi_araddr_i)
                    `TCG_OFF_CTL0: s_axi_rdata_o <= {24'h0, timer_control_first};
                    `TCG_OFF_CTL1: s_axi_rdata_o <= {24'h0, timer_control_second};
                    `TCG_OFF_IOC0: s_axi_rdata_o <= {28'h0, timer_output_control};
                    `TCG_OFF_CNT: s_axi_rdata_o <= {{(32-CNT_W){1'b0}}, count};
                    default: begin
                        // unmapped: zero data with an error answer
                        s_axi_rdata_o <= 32'h0;
                        s_axi_rresp_o <= `TCG_RESP_SLVERR;
                    end
                endcase
            end
            if (s_axi_rvalid_o && s_axi_rready_i) begin
                s_axi_rvalid_o <= 1'b0;
                s_axi_arready_o <= 1'b1;
            end
        end
    end

    // ----------------------------------------------------------------
    // counter, software trigger and output pins
    // ----------------------------------------------------------------
    reg count_src; // chosen count source pulse

    // event count mode forces the external input whatever eee says
    always @* begin
        if (mode == `TCG_MD_EXT_EVENT) begin
            count_src = ev_edge;
        end else if (eee) begin
            count_src = ev_edge;
        end else begin
            count_src = tick;
        end
    end

    // counter runs only while enabled, pins follow their level bits
    always @(posedge core_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            count <= {CNT_W{1'b0}};
            ev_d <= 1'b0;
            trigger_pulse_o <= 1'b0;
            timer_output_pin_o <= 2'h0;
        end else begin
            ev_d <= ext_event_i;
            // hold when stopped, advance on the source when running
            if (!count_enable) begin
                count <= count;
            end else if (count_src) begin
                count <= count + {{(CNT_W-1){1'b0}}, 1'b1};
            end
            // trigger only in trigger modes, else the write is dropped
            // the mode written in the same access decides, not the old one
            trigger_pulse_o <= sw_trig_wr && trig_mode(w_data[`TCG_CTL1_MD_HI:`TCG_CTL1_MD_LO]);
            // level bit reaches the pin even when stopped and disabled
            timer_output_pin_o <= {timer_output_control[`TCG_IOC0_OL1],
                                   timer_output_control[`TCG_IOC0_OL0]};
        end
    end

endmodule // tcg_timer_cfg

// [test/tcg_timer_cfg_properties.sv]
// checker for the timer configuration block: bus answers and pin relations
// sees only the top ports; bound from the testbench top file
`timescale 1ns/10ps
`include "tcg_defines.vh"
module tcg_timer_cfg_properties (
    // clock and reset
    input wire core_clk_i,
    input wire resetn_i,
    // write side of the bus
    input wire [3:0] s_axi_awaddr_i,
    input wire s_axi_awvalid_i,
    input wire s_axi_awready_o,
    input wire [31:0] s_axi_wdata_i,
    input wire s_axi_wvalid_i,
    input wire s_axi_wready_o,
    input wire [1:0] s_axi_bresp_o,
    input wire s_axi_bvalid_o,
    input wire s_axi_bready_i,
    // read side of the bus
    input wire s_axi_arvalid_i,
    input wire s_axi_arready_o,
    input wire s_axi_rvalid_o,
    // timer pins
    input wire [1:0] timer_output_pin_o,
    input wire trigger_pulse_o
);
// ----------------------------------------
// shadow of the last accepted write
// ----------------------------------------
reg [3:0] aq; // address taken
reg [31:0] dq; // data taken
wire trig_mode = (dq[2:0] == `TCG_MD_EXT_TRIG) || (dq[2:0] == `TCG_MD_ONE_SHOT);
// capture on each channel's own handshake, they may arrive apart
always @(posedge core_clk_i) begin
    if (s_axi_awvalid_i && s_axi_awready_o) aq <= s_axi_awaddr_i;
    if (s_axi_wvalid_i && s_axi_wready_o) dq <= s_axi_wdata_i;
end
default clocking @(posedge core_clk_i); endclocking
default disable iff (!resetn_i);
// ----------------------------------------
// assertions
// ----------------------------------------
a_pin_follows_level: assert property (
    $rose(s_axi_bvalid_o) && aq == `TCG_OFF_IOC0
    |-> ##[1:2] timer_output_pin_o == {dq[`TCG_IOC0_OL1], dq[`TCG_IOC0_OL0]})
    else $error("output pins do not follow level bits");
a_trig_fires: assert property (
    $rose(s_axi_bvalid_o) && aq == `TCG_OFF_CTL1 && dq[`TCG_CTL1_EST] && trig_mode
    |-> ##[0:2] trigger_pulse_o)
    else $error("software trigger in pulse mode gave no pulse");
a_trig_ignored: assert property (
    $rose(s_axi_bvalid_o) && aq == `TCG_OFF_CTL1 && !(dq[`TCG_CTL1_EST] && trig_mode)
    |-> !trigger_pulse_o [*3])
    else $error("trigger pulse outside pulse modes");
a_trig_single: assert property (trigger_pulse_o |=> !trigger_pulse_o)
    else $error("trigger pulse longer than one cycle");
a_cnt_refused: assert property (
    $rose(s_axi_bvalid_o) && aq == `TCG_OFF_CNT |-> s_axi_bresp_o == `TCG_RESP_SLVERR)
    else $error("counter write not refused");
a_write_okay: assert property (
    $rose(s_axi_bvalid_o) && aq != `TCG_OFF_CNT && aq[1:0] == 2'h0
    |-> s_axi_bresp_o == `TCG_RESP_OKAY)
    else $error("register write refused");
a_aw_busy: assert property (
    s_axi_awvalid_i && s_axi_awready_o |=> !s_axi_awready_o [*2])
    else $error("write address accepted twice");
a_read_answer: assert property (
    s_axi_arvalid_i && s_axi_arready_o |=> s_axi_rvalid_o)
    else $error("read answer late");
a_resp_once: assert property (s_axi_bvalid_o && s_axi_bready_i |=> !s_axi_bvalid_o)
    else $error("write response repeated");
endmodule // tcg_timer_cfg_properties

// [test/tcg_timer_cfg_tb.sv]
// self-checking bench for the timer configuration block
// drives the bus and event pin itself; results checked from queues
`timescale 1ns/10ps
`include "tcg_defines.vh"
module tcg_timer_cfg_tb;
reg clk = 0, rstn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0, ev = 0;
reg [3:0] awaddr = 0, araddr = 0;
reg [31:0] wdata = 0, v;
wire awready, wready, bvalid, arready, rvalid, trig;
wire [1:0] bresp, rresp, pins;
wire [31:0] rdata;
integer failures = 0, compares = 0, pulses = 0, n, m;
reg [1:0] bq[$]; // expected write responses
reg [31:0] rq[$]; // expected read data
tcg_timer_cfg tcg_timer_cfg_inst (.core_clk_i(clk), .resetn_i(rstn),
    .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
    .s_axi_wdata_i(wdata), .s_axi_wstrb_i(4'hf), .s_axi_wvalid_i(wvalid),
    .s_axi_wready_o(wready), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid),
    .s_axi_bready_i(bready), .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
    .s_axi_arready_o(arready), .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp),
    .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready), .ext_event_i(ev),
    .timer_output_pin_o(pins), .trigger_pulse_o(trig));
initial forever #20 clk = ~clk;
task chk(input string what, input [31:0] e, input [31:0] g);
    begin
        compares = compares + 1;
        if (g !== e) begin
            failures = failures + 1;
            $display("CHECK FAILED %s expected %h seen %h", what, e, g);
        end
    end
endtask
task print_verdict;
    begin
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    end
endtask
// one write: address and data offered together, each released when taken
task wr(input [3:0] a, input [31:0] d, input [1:0] r);
    integer k;
    reg done;
    begin
        done = 0;
        bq.push_back(r);
        @(posedge clk);
        awaddr <= a; wdata <= d; awvalid <= 1; wvalid <= 1; bready <= 1;
        for (k = 0; k < 50 && !done; k = k + 1) begin
            @(posedge clk);
            if (awready) awvalid <= 0;
            if (wready) wvalid <= 0;
            if (bvalid) begin bready <= 0; done = 1; end
        end
        if (!done) begin failures = failures + 1; print_verdict; end
    end
endtask
task rd(input [3:0] a, input [31:0] e);
    integer k;
    reg done;
    begin
        done = 0;
        rq.push_back(e);
        @(posedge clk);
        araddr <= a; arvalid <= 1; rready <= 1;
        for (k = 0; k < 50 && !done; k = k + 1) begin
            @(posedge clk);
            if (arready) arvalid <= 0;
            if (rvalid) begin rready <= 0; done = 1; end
        end
        if (!done) begin failures = failures + 1; print_verdict; end
    end
endtask
// event pulse held three cycles high, then three low, for the edge detector
task ev_pulse;
    begin
        @(posedge clk) ev <= 1;
        repeat (3) @(posedge clk);
        ev <= 0;
        repeat (3) @(posedge clk);
    end
endtask
// monitor: answers are matched with the oldest note at their handshake
always @(posedge clk) begin
    if (bvalid && bready) chk("bresp", bq.pop_front(), bresp);
    if (rvalid && rready) chk("rdata", rq.pop_front(), rdata);
    if (rvalid && rready) chk("rresp", `TCG_RESP_OKAY, rresp);
    if (trig === 1'b1) pulses = pulses + 1;
end
initial begin
    v = $urandom(53);
    repeat (4) @(posedge clk);
    rstn <= 1;
    repeat (3) @(posedge clk);
    rd(`TCG_OFF_CTL0, 0); rd(`TCG_OFF_CTL1, 0); rd(`TCG_OFF_IOC0, 0);
    chk("pins", 0, pins);
    $display("test reset values done");
    wr(`TCG_OFF_CTL0, 32'h7f, `TCG_RESP_OKAY);
    rd(`TCG_OFF_CTL0, 32'h07);
    wr(`TCG_OFF_CTL1, 32'h1d, `TCG_RESP_OKAY);
    rd(`TCG_OFF_CTL1, 32'h05);
    $display("test reserved bits done");
    for (m = 0; m < 4; m = m + 1) begin
        v = $urandom;
        wr(`TCG_OFF_IOC0, {28'h0, v[3:0]}, `TCG_RESP_OKAY);
        repeat (2) @(posedge clk);
        chk("pins", {30'h0, v[3], v[1]}, {30'h0, pins});
        rd(`TCG_OFF_IOC0, {28'h0, v[3:0]});
    end
    $display("test output levels done");
    for (m = 0; m < 8; m = m + 1) begin
        n = pulses;
        wr(`TCG_OFF_CTL1, 32'h40 | m, `TCG_RESP_OKAY);
        repeat (3) @(posedge clk);
        chk("pulses", (m == 2 || m == 3), pulses - n);
        rd(`TCG_OFF_CTL1, m);
    end
    $display("test software trigger done");
    wr(`TCG_OFF_CTL1, {29'h0, `TCG_MD_EXT_EVENT}, `TCG_RESP_OKAY);
    wr(`TCG_OFF_CTL0, 32'h80, `TCG_RESP_OKAY);
    repeat (5) ev_pulse;
    wr(`TCG_OFF_CTL0, 0, `TCG_RESP_OKAY);
    rd(`TCG_OFF_CNT, 5);
    repeat (3) ev_pulse;
    rd(`TCG_OFF_CNT, 5);
    wr(`TCG_OFF_CNT, 32'h1234, `TCG_RESP_SLVERR);
    rd(`TCG_OFF_CNT, 5);
    $display("test event count done");
    print_verdict;
end
endmodule // tcg_timer_cfg_tb
bind tcg_timer_cfg tcg_timer_cfg_properties tcg_timer_cfg_properties_inst (
    .core_clk_i(core_clk_i), .resetn_i(resetn_i), .s_axi_awaddr_i(s_axi_awaddr_i),
    .s_axi_awvalid_i(s_axi_awvalid_i), .s_axi_awready_o(s_axi_awready_o),
    .s_axi_wdata_i(s_axi_wdata_i), .s_axi_wvalid_i(s_axi_wvalid_i),
    .s_axi_wready_o(s_axi_wready_o), .s_axi_bresp_o(s_axi_bresp_o),
    .s_axi_bvalid_o(s_axi_bvalid_o), .s_axi_bready_i(s_axi_bready_i),
    .s_axi_arvalid_i(s_axi_arvalid_i), .s_axi_arready_o(s_axi_arready_o),
    .s_axi_rvalid_o(s_axi_rvalid_o), .timer_output_pin_o(timer_output_pin_o),
    .trigger_pulse_o(trigger_pulse_o));
